// ==== design/ptp_pkg.sv ====
// constants, field layout and types of the ptp system time unit
package ptp_pkg;
	// register byte offsets
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_TS_CTRL = 12'h700;
	localparam logic [11:0] OFF_SSINC = 12'h704;
	localparam logic [11:0] OFF_TIME_SEC = 12'h708;
	localparam logic [11:0] OFF_TIME_SUB = 12'h70C;
	localparam logic [11:0] OFF_UPD_SEC = 12'h710;
	localparam logic [11:0] OFF_UPD_SUB = 12'h714;
	localparam logic [11:0] OFF_ADDEND = 12'h718;
	localparam logic [11:0] OFF_TGT_SEC = 12'h71C;
	localparam logic [11:0] OFF_TGT_NS = 12'h720;
	localparam logic [11:0] OFF_FLAGS = 12'h728;
	localparam logic [11:0] OFF_PPS_CTRL = 12'h72C;
	// reset values and writable masks
	localparam logic [31:0] TS_CTRL_RESET = 32'h0000_2000;
	localparam logic [31:0] TS_CTRL_MASK = 32'h0007_FF3F;
	localparam logic [31:0] REG_RESET = 32'h0000_0000;
	localparam logic [31:0] SSINC_MASK = 32'h0000_00FF;
	localparam logic [31:0] PPS_MASK = 32'h0000_000F;
	// timestamp control fields
	localparam int CTL_TS_EN = 0;
	localparam int CTL_FINE = 1;
	localparam int CTL_INIT = 2;
	localparam int CTL_UPD = 3;
	localparam int CTL_TGT_IE = 4;
	localparam int CTL_ADD_UPD = 5;
	localparam int CTL_ALL = 8;
	localparam int CTL_ROLL = 9;
	localparam int CTL_VER = 10;
	localparam int CTL_RAW = 11;
	localparam int CTL_IP6 = 12;
	localparam int CTL_IP4 = 13;
	localparam int CTL_EVT = 14;
	localparam int CTL_MST = 15;
	localparam int CTL_NODE = 16;
	// flag and sign fields
	localparam int FLG_OVF = 0;
	localparam int FLG_MATCH = 1;
	localparam int SIGN_BIT = 31;
	// subsecond rollover points
	localparam logic [30:0] ROLL_BINARY = 31'h7FFF_FFFF;
	localparam logic [30:0] ROLL_DIGITAL = 31'h3B9A_C9FF;
	// pps pulse width for code zero, in ms, and in subsecond units
	localparam int PPS_WIDTH_BINARY_MS = 125;
	localparam int PPS_WIDTH_DIGITAL_MS = 100;
	localparam logic [30:0] PPS_WIDTH_BINARY_SUB =
		31'((64'h8000_0000 * PPS_WIDTH_BINARY_MS) / 1000);
	localparam logic [30:0] PPS_WIDTH_DIGITAL_SUB =
		31'(PPS_WIDTH_DIGITAL_MS * 1_000_000);
	typedef enum logic [1:0] {
		CLASS_OTHER = 2'b00,
		CLASS_RAW = 2'b01,
		CLASS_IPV4 = 2'b10,
		CLASS_IPV6 = 2'b11
	} frame_class_type;
	typedef enum logic [1:0] {
		NODE_ORDINARY = 2'b00,
		NODE_BOUNDARY = 2'b01,
		NODE_E2E = 2'b10,
		NODE_P2P = 2'b11
	} node_type_type;
	// message kinds in version 2 numbering
	typedef enum logic [3:0] {
		MSG_SYNC = 4'h0,
		MSG_DELAY_REQ = 4'h1,
		MSG_PDELAY_REQ = 4'h2,
		MSG_PDELAY_RESP = 4'h3,
		MSG_FOLLOW_UP = 4'h8,
		MSG_DELAY_RESP = 4'h9,
		MSG_PDELAY_FUP = 4'hA,
		MSG_ANNOUNCE = 4'hB,
		MSG_SIGNALING = 4'hC,
		MSG_MANAGEMENT = 4'hD,
		MSG_NONE = 4'hF
	} msg_type_type;
endpackage

// ==== design/snap_if.sv ====
// snapshot selection signals between the time unit and its filter
`timescale 1ns/1ns
`default_nettype none
interface snap_if;
	logic ts_enable;
	logic all_frames;
	logic version2;
	logic ipv4_en;
	logic ipv6_en;
	logic raw_en;
	logic event_only;
	logic master_sel;
	logic [1:0] node_type;
	logic frame_valid;
	logic [1:0] frame_class;
	logic [7:0] msg_field;
	logic take;
	modport owner (
		output ts_enable, all_frames, version2, ipv4_en, ipv6_en, raw_en,
		output event_only, master_sel, node_type,
		output frame_valid, frame_class, msg_field,
		input take
	);
	modport filter (
		input ts_enable, all_frames, version2, ipv4_en, ipv6_en, raw_en,
		input event_only, master_sel, node_type,
		input frame_valid, frame_class, msg_field,
		output take
	);
endinterface
`default_nettype wire

// ==== design/snapshot_filter.sv ====
// received frame snapshot selection by class, node type and message
`timescale 1ns/1ns
`default_nettype none
module snapshot_filter (
	// selection settings and frame facts
	snap_if.filter sif
);
	// version 1 control field mapped onto version 2 kinds
	function automatic ptp_pkg::msg_type_type kind_of(
		input logic v2, input logic [7:0] field);
		ptp_pkg::msg_type_type k;
		k = ptp_pkg::MSG_NONE;
		if (v2) begin
			k = ptp_pkg::msg_type_type'(field[3:0]);
		end else begin
			case (field)
				8'h00: k = ptp_pkg::MSG_SYNC;
				8'h01: k = ptp_pkg::MSG_DELAY_REQ;
				8'h02: k = ptp_pkg::MSG_FOLLOW_UP;
				8'h03: k = ptp_pkg::MSG_DELAY_RESP;
				8'h04: k = ptp_pkg::MSG_MANAGEMENT;
				default: k = ptp_pkg::MSG_NONE;
			endcase
		end
		return k;
	endfunction
	logic class_ok;
	logic type_ok;
	ptp_pkg::msg_type_type kind;
	logic is_sync, is_dreq, is_fup, is_dresp, is_pdreq, is_pdresp, is_gen;
	assign kind = kind_of(sif.version2, sif.msg_field);
	assign is_sync = (kind == ptp_pkg::MSG_SYNC);
	assign is_dreq = (kind == ptp_pkg::MSG_DELAY_REQ);
	assign is_fup = (kind == ptp_pkg::MSG_FOLLOW_UP);
	assign is_dresp = (kind == ptp_pkg::MSG_DELAY_RESP);
	assign is_pdreq = (kind == ptp_pkg::MSG_PDELAY_REQ);
	assign is_pdresp = (kind == ptp_pkg::MSG_PDELAY_RESP);
	// any valid kind other than announce, management, signaling
	assign is_gen = (kind != ptp_pkg::MSG_ANNOUNCE) &&
		(kind != ptp_pkg::MSG_MANAGEMENT) &&
		(kind != ptp_pkg::MSG_SIGNALING) && (kind != ptp_pkg::MSG_NONE);
	// per class enables; untyped frames never qualify
	always_comb begin
		case (ptp_pkg::frame_class_type'(sif.frame_class))
			ptp_pkg::CLASS_IPV4: class_ok = sif.ipv4_en;
			ptp_pkg::CLASS_IPV6: class_ok = sif.ipv6_en;
			ptp_pkg::CLASS_RAW: class_ok = sif.raw_en;
			default: class_ok = 1'b0;
		endcase
	end
	// message table per node type and event-only setting
	always_comb begin
		case (ptp_pkg::node_type_type'(sif.node_type))
			ptp_pkg::NODE_ORDINARY, ptp_pkg::NODE_BOUNDARY: begin
				if (sif.event_only) begin
					// master side stamps requests, slave side syncs
					type_ok = sif.master_sel ? is_dreq : is_sync;
				end else begin
					type_ok = is_sync | is_fup | is_dreq | is_dresp;
				end
			end
			ptp_pkg::NODE_E2E: begin
				type_ok = sif.event_only ? (is_sync | is_fup) :
					(is_sync | is_fup | is_dreq | is_dresp);
			end
			ptp_pkg::NODE_P2P: begin
				// event-only narrows to event kinds, else all but announce, management, signaling
				type_ok = sif.event_only ? (is_sync | is_pdreq | is_pdresp) :
					is_gen;
			end
			default: type_ok = 1'b0;
		endcase
	end
	// all-frames mode bypasses the class and message filters
	assign sif.take = sif.frame_valid & sif.ts_enable &
		(sif.all_frames | (class_ok & type_ok));
endmodule
`default_nettype wire

// ==== design/ptp_system_time_unit.sv ====
// ptp system time keeping, target compare, pps and frame snapshots
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - event-only clear on peer-to-peer nodes stamps all kinds but announce, management, signaling
// - separate enables for ipv4, ipv6 and raw ethernet ptp frames
// - version bit picks version 1 or version 2 message parsing
// - subseconds wrap after 0x7FFFFFFF binary or 0x3B9AC9FF digital
// - all-frames enable stamps every received frame
// - addend update bit loads addend into fine logic, self clears
// - target interrupt fires once time reaches or passes target; enable self clears
// - update bit adds or subtracts update value, then self clears
// - initialize bit loads time from update registers, then self clears
// - method bit picks coarse or fine accumulator advance
// - timestamp enable gates stamping; software initializes time after
// - ordinary and boundary node message selection table
// - transparent end-to-end and peer-to-peer message selection
// - 8-bit increment added each cycle coarse, each overflow fine
// - fine mode adds addend to 32-bit accumulator each cycle
// - time readable as seconds plus sign and 31-bit subseconds
// - update sign adds when 0, subtracts when 1; 0 for init
// - match flag set at or past target while target interrupt enabled; flag read clears it
// - seconds overflow flag set when seconds pass 0xFFFFFFFF
// - 4-bit pps code; code 0 is 1 Hz, 125 or 100 ms
// - nonzero pps codes give 2^code Hz at half duty with binary rollover
// - two-bit node type selects snapshot behaviour
// - master select matters only for ordinary and boundary nodes
module ptp_system_time_unit (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ptp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// receive frame path
	input wire logic rx_frame_valid,
	input wire logic [1:0] rx_frame_class,
	input wire logic [7:0] rx_msg_field,
	output logic rx_snap_valid,
	output logic [31:0] rx_snap_seconds,
	output logic [31:0] rx_snap_subseconds,
	// transmit frame path
	input wire logic tx_frame_start,
	output logic tx_snap_valid,
	output logic [31:0] tx_snap_seconds,
	output logic [31:0] tx_snap_subseconds,
	// time outputs
	output logic pps_out,
	output logic ts_irq
);
	// byte lane merge of a write into an old value
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction
	// highest subsecond value before wrap
	function automatic logic [30:0] roll_max(input logic digital);
		return digital ? ptp_pkg::ROLL_DIGITAL : ptp_pkg::ROLL_BINARY;
	endfunction
	// mapped offsets
	function automatic logic hit(input logic [ptp_pkg::ADDR_W-1:0] a);
		case (a)
			ptp_pkg::OFF_TS_CTRL, ptp_pkg::OFF_SSINC,
			ptp_pkg::OFF_TIME_SEC, ptp_pkg::OFF_TIME_SUB,
			ptp_pkg::OFF_UPD_SEC, ptp_pkg::OFF_UPD_SUB,
			ptp_pkg::OFF_ADDEND, ptp_pkg::OFF_TGT_SEC,
			ptp_pkg::OFF_TGT_NS, ptp_pkg::OFF_FLAGS,
			ptp_pkg::OFF_PPS_CTRL: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction
	logic [31:0] ctrl_q, ssinc_q, upd_sec_q, upd_sub_q, addend_q;
	logic [31:0] tgt_sec_q, tgt_ns_q, pps_ctrl_q, prdata_q;
	logic [31:0] addend_act_q, acc_q, sec_q, hw_clr;
	logic [30:0] sub_q, rmax;
	logic sign_q, match_q, ovf_q, irq_q;
	logic setup, access, wr, rd_setup;
	logic ts_en, fine, do_init, do_upd, do_add, tick, acc_carry;
	logic [31:0] acc_sum, sub_span, sub_inc, sub_add, sub_dif;
	logic [32:0] sec_add, sec_dif;
	logic reach, match_ev, ovf_ev, flag_rd;
	snap_if sif ();
	// apb phases; zero wait, data already captured at setup
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr = access & pwrite & hit(paddr);
	assign rd_setup = setup & ~pwrite;
	assign pready = 1'b1;
	assign pslverr = access & ~hit(paddr);
	assign prdata = prdata_q;
	assign ts_en = ctrl_q[ptp_pkg::CTL_TS_EN];
	assign fine = ctrl_q[ptp_pkg::CTL_FINE];
	assign do_init = ctrl_q[ptp_pkg::CTL_INIT];
	assign do_upd = ctrl_q[ptp_pkg::CTL_UPD] & ~do_init;
	assign do_add = ctrl_q[ptp_pkg::CTL_ADD_UPD];
	assign rmax = roll_max(ctrl_q[ptp_pkg::CTL_ROLL]);
	assign sub_span = {1'b0, rmax} + 32'h0000_0001;
	// hardware clears each request bit on the same edge that acts on it
	always_comb begin
		hw_clr = 32'h0000_0000;
		hw_clr[ptp_pkg::CTL_INIT] = do_init;
		hw_clr[ptp_pkg::CTL_UPD] = do_upd;
		hw_clr[ptp_pkg::CTL_ADD_UPD] = do_add;
		hw_clr[ptp_pkg::CTL_TGT_IE] = match_ev;
	end
	// control register; a software write wins over a hardware clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= ptp_pkg::TS_CTRL_RESET;
		end else if (wr && paddr == ptp_pkg::OFF_TS_CTRL) begin
			ctrl_q <= merge(ctrl_q, pwdata, pstrb) & ptp_pkg::TS_CTRL_MASK;
		end else begin
			ctrl_q <= ctrl_q & ~hw_clr;
		end
	end
	// plain read-write registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ssinc_q <= ptp_pkg::REG_RESET;
			upd_sec_q <= ptp_pkg::REG_RESET;
			upd_sub_q <= ptp_pkg::REG_RESET;
			addend_q <= ptp_pkg::REG_RESET;
			tgt_sec_q <= ptp_pkg::REG_RESET;
			tgt_ns_q <= ptp_pkg::REG_RESET;
			pps_ctrl_q <= ptp_pkg::REG_RESET;
		end else if (wr) begin
			case (paddr)
				ptp_pkg::OFF_SSINC:
					ssinc_q <= merge(ssinc_q, pwdata, pstrb) & ptp_pkg::SSINC_MASK;
				ptp_pkg::OFF_UPD_SEC: upd_sec_q <= merge(upd_sec_q, pwdata, pstrb);
				ptp_pkg::OFF_UPD_SUB: upd_sub_q <= merge(upd_sub_q, pwdata, pstrb);
				ptp_pkg::OFF_ADDEND: addend_q <= merge(addend_q, pwdata, pstrb);
				ptp_pkg::OFF_TGT_SEC: tgt_sec_q <= merge(tgt_sec_q, pwdata, pstrb);
				ptp_pkg::OFF_TGT_NS: tgt_ns_q <= merge(tgt_ns_q, pwdata, pstrb);
				ptp_pkg::OFF_PPS_CTRL:
					pps_ctrl_q <= merge(pps_ctrl_q, pwdata, pstrb) & ptp_pkg::PPS_MASK;
				default: ;
			endcase
		end
	end
	// read data captured at setup so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			case (paddr)
				ptp_pkg::OFF_TS_CTRL: prdata_q <= ctrl_q;
				ptp_pkg::OFF_SSINC: prdata_q <= ssinc_q;
				ptp_pkg::OFF_TIME_SEC: prdata_q <= sec_q;
				ptp_pkg::OFF_TIME_SUB: prdata_q <= {sign_q, sub_q};
				ptp_pkg::OFF_UPD_SEC: prdata_q <= upd_sec_q;
				ptp_pkg::OFF_UPD_SUB: prdata_q <= upd_sub_q;
				ptp_pkg::OFF_ADDEND: prdata_q <= addend_q;
				ptp_pkg::OFF_TGT_SEC: prdata_q <= tgt_sec_q;
				ptp_pkg::OFF_TGT_NS: prdata_q <= tgt_ns_q;
				ptp_pkg::OFF_FLAGS: prdata_q <= {30'h0000_0000, match_q, ovf_q};
				ptp_pkg::OFF_PPS_CTRL: prdata_q <= pps_ctrl_q;
				default: prdata_q <= 32'h0000_0000;
			endcase
		end
	end
	// addend moves to the accumulator path only on request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addend_act_q <= 32'h0000_0000;
		end else if (do_add) begin
			addend_act_q <= addend_q;
		end
	end
	// fine accumulator; its carry paces the time in fine mode
	assign acc_sum = acc_q + addend_act_q;
	assign acc_carry = (acc_sum < acc_q);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 32'h0000_0000;
		end else if (ts_en && fine) begin
			acc_q <= acc_sum;
		end
	end
	assign tick = ts_en & (fine ? acc_carry : 1'b1);
	// subsecond arithmetic in 32 bits so the wrap test cannot overflow
	assign sub_inc = {1'b0, sub_q} + {24'h00_0000, ssinc_q[7:0]};
	assign sub_add = {1'b0, sub_q} + {1'b0, upd_sub_q[30:0]};
	assign sub_dif = {1'b0, sub_q} - {1'b0, upd_sub_q[30:0]};
	assign sec_add = {1'b0, sec_q} + {1'b0, upd_sec_q} +
		{32'h0000_0000, (sub_add >= sub_span)};
	assign sec_dif = {1'b0, sec_q} - {1'b0, upd_sec_q} -
		{32'h0000_0000, sub_dif[31]};
	// system time: initialize, then offset update, then normal advance
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_q <= 32'h0000_0000;
			sub_q <= 31'h0000_0000;
			sign_q <= 1'b0;
		end else if (do_init) begin
			sec_q <= upd_sec_q;
			sub_q <= upd_sub_q[30:0];
			sign_q <= 1'b0;
		end else if (do_upd) begin
			if (!upd_sub_q[ptp_pkg::SIGN_BIT]) begin
				sec_q <= sec_add[31:0];
				sub_q <= (sub_add >= sub_span) ?
					31'(sub_add - sub_span) : sub_add[30:0];
			end else begin
				// borrow below zero seconds only flags the sign
				sec_q <= sec_dif[31:0];
				sub_q <= sub_dif[31] ? 31'(sub_dif + sub_span) : sub_dif[30:0];
				sign_q <= sec_dif[32];
			end
		end else if (tick) begin
			if (sub_inc > {1'b0, rmax}) begin
				sub_q <= 31'(sub_inc - sub_span);
				sec_q <= sec_q + 32'h0000_0001;
			end else begin
				sub_q <= sub_inc[30:0];
			end
		end
	end
	// seconds wrap events from advance or offset add
	assign ovf_ev = (tick && !do_init && !do_upd && sub_inc > {1'b0, rmax} &&
		sec_q == 32'hFFFF_FFFF) ||
		(do_upd && !upd_sub_q[ptp_pkg::SIGN_BIT] && sec_add[32]);
	// unsigned compare on magnitudes; the nanosecond sign bit is ignored
	assign reach = ts_en && ({sec_q, sub_q} >= {tgt_sec_q, tgt_ns_q[30:0]});
	assign match_ev = reach & ctrl_q[ptp_pkg::CTL_TGT_IE];
	assign flag_rd = rd_setup && paddr == ptp_pkg::OFF_FLAGS;
	// sticky flags; a new event beats the clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q <= 1'b0;
		end else if (match_ev) begin
			match_q <= 1'b1;
		end else if (flag_rd) begin
			match_q <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ovf_q <= 1'b0;
		end else if (ovf_ev) begin
			ovf_q <= 1'b1;
		end else if (wr && paddr == ptp_pkg::OFF_FLAGS &&
			pstrb[0] && pwdata[ptp_pkg::FLG_OVF]) begin
			ovf_q <= 1'b0;
		end
	end
	// one pulse per match; enable clears so it fires once
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= match_ev;
		end
	end
	assign ts_irq = irq_q;
	// pps from subsecond bits; digital rollover only exact for code 0
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pps_out <= 1'b0;
		end else if (!ts_en) begin
			pps_out <= 1'b0;
		end else if (pps_ctrl_q[3:0] == 4'h0) begin
			pps_out <= sub_q < (ctrl_q[ptp_pkg::CTL_ROLL] ?
				ptp_pkg::PPS_WIDTH_DIGITAL_SUB :
				ptp_pkg::PPS_WIDTH_BINARY_SUB);
		end else begin
			pps_out <= sub_q[5'd30 - {1'b0, pps_ctrl_q[3:0]}];
		end
	end
	// settings and frame facts for the receive filter
	assign sif.ts_enable = ts_en;
	assign sif.all_frames = ctrl_q[ptp_pkg::CTL_ALL];
	assign sif.version2 = ctrl_q[ptp_pkg::CTL_VER];
	assign sif.ipv4_en = ctrl_q[ptp_pkg::CTL_IP4];
	assign sif.ipv6_en = ctrl_q[ptp_pkg::CTL_IP6];
	assign sif.raw_en = ctrl_q[ptp_pkg::CTL_RAW];
	assign sif.event_only = ctrl_q[ptp_pkg::CTL_EVT];
	assign sif.master_sel = ctrl_q[ptp_pkg::CTL_MST];
	assign sif.node_type = ctrl_q[ptp_pkg::CTL_NODE +: 2];
	assign sif.frame_valid = rx_frame_valid;
	assign sif.frame_class = rx_frame_class;
	assign sif.msg_field = rx_msg_field;
	snapshot_filter u_filter (
		.sif(sif.filter)
	);
	// receive snapshot holds until the next taken frame
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_snap_valid <= 1'b0;
			rx_snap_seconds <= 32'h0000_0000;
			rx_snap_subseconds <= 32'h0000_0000;
		end else begin
			rx_snap_valid <= sif.take;
			if (sif.take) begin
				rx_snap_seconds <= sec_q;
				rx_snap_subseconds <= {sign_q, sub_q};
			end
		end
	end
	// transmit snapshot at frame start while stamping is on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_snap_valid <= 1'b0;
			tx_snap_seconds <= 32'h0000_0000;
			tx_snap_subseconds <= 32'h0000_0000;
		end else begin
			tx_snap_valid <= tx_frame_start & ts_en;
			if (tx_frame_start && ts_en) begin
				tx_snap_seconds <= sec_q;
				tx_snap_subseconds <= {sign_q, sub_q};
			end
		end
	end
endmodule
`default_nettype wire

// ==== verification/ptp_system_time_unit_assertions.sv ====
// port-level assertions for the ptp system time unit
`timescale 1ns/1ns
`default_nettype none
module ptp_system_time_unit_assertions (
	// clock, reset and apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ptp_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// frame paths and interrupt
	input wire logic rx_frame_valid,
	input wire logic rx_snap_valid,
	input wire logic tx_frame_start,
	input wire logic tx_snap_valid,
	input wire logic ts_irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic rd_acc, ctl_wr, ts_q, all_q, roll_q, ie_q;
	assign rd_acc = psel && penable && !pwrite;
	assign ctl_wr = psel && penable && pwrite && paddr == ptp_pkg::OFF_TS_CTRL;
	// shadow of written control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{ts_q, all_q, roll_q, ie_q} <= 4'h0;
		end else if (ctl_wr) begin
			ts_q <= pwdata[ptp_pkg::CTL_TS_EN];
			all_q <= pwdata[ptp_pkg::CTL_ALL];
			roll_q <= pwdata[ptp_pkg::CTL_ROLL];
			ie_q <= pwdata[ptp_pkg::CTL_TGT_IE];
		end else if (ts_irq) begin
			ie_q <= 1'b0;
		end
	end
	property p_rx_all;
		rx_frame_valid && ts_q && all_q |=> rx_snap_valid;
	endproperty
	a_rx_all: assert property (p_rx_all) else $error("frame not stamped");
	property p_rx_off;
		rx_frame_valid && !ts_q |=> !rx_snap_valid;
	endproperty
	a_rx_off: assert property (p_rx_off) else $error("stamp while off");
	property p_snap_cause;
		rx_snap_valid |-> $past(rx_frame_valid);
	endproperty
	a_snap_cause: assert property (p_snap_cause) else $error("stray stamp");
	property p_tx;
		tx_frame_start |=> tx_snap_valid == $past(ts_q);
	endproperty
	a_tx: assert property (p_tx) else $error("tx stamp wrong");
	property p_irq_pulse;
		ts_irq |=> !ts_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("irq too long");
	property p_irq_once;
		ts_irq |-> ie_q;
	endproperty
	a_irq_once: assert property (p_irq_once) else $error("irq not enabled");
	property p_roll;
		rd_acc && paddr == ptp_pkg::OFF_TIME_SUB && roll_q
			|-> prdata[30:0] <= ptp_pkg::ROLL_DIGITAL;
	endproperty
	a_roll: assert property (p_roll) else $error("subseconds past wrap");
	property p_ssinc_resv;
		rd_acc && paddr == ptp_pkg::OFF_SSINC |-> prdata[31:8] == 24'h0;
	endproperty
	a_ssinc_resv: assert property (p_ssinc_resv) else $error("increment high bits");
	c_rx: cover property (rx_snap_valid);
	c_tx: cover property (tx_snap_valid);
	c_irq: cover property (ts_irq);
endmodule
bind ptp_system_time_unit ptp_system_time_unit_assertions chk (
	.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .prdata,
	.rx_frame_valid, .rx_snap_valid,
	.tx_frame_start, .tx_snap_valid,
	.ts_irq
);
`default_nettype wire

// ==== verification/mac_frame_model.sv ====
// model of the mac receive and transmit frame paths
`timescale 1ns/1ns
`default_nettype none
module mac_frame_model (
	// clock
	input wire logic pclk,
	// frame events toward the time unit
	output logic rx_frame_valid,
	output logic [1:0] rx_frame_class,
	output logic [7:0] rx_msg_field,
	output logic tx_frame_start
);
	initial begin
		{rx_frame_valid, rx_frame_class, rx_msg_field, tx_frame_start} = '0;
	end
	// one-cycle pulse; fields inverted after so stale ones fail
	task automatic send(input logic tx, input logic [1:0] c,
		input logic [7:0] m);
		@(posedge pclk);
		rx_frame_valid <= !tx;
		tx_frame_start <= tx;
		rx_frame_class <= c;
		rx_msg_field <= m;
		@(posedge pclk);
		rx_frame_valid <= 1'b0;
		tx_frame_start <= 1'b0;
		rx_frame_class <= ~c;
		rx_msg_field <= ~m;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// ==== verification/ptp_system_time_unit_tb.sv ====
// self-checking bench for the ptp system time unit
`timescale 1ns/1ns
`default_nettype none
module ptp_system_time_unit_tb;
	logic pclk, presetn, psel, penable, pwrite, pready;
	logic rxv, txv, pps, irq, rfv, tfs;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r1, rxs, rxu, txs, txu, ctl, inc;
	logic [3:0] pstrb;
	logic [1:0] rcl;
	logic [7:0] rmf;
	logic [3:0] mt [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hB};
	int n_errors, check_count, cyc, n_irq;
	logic [31:0] rdq[$], rmq[$], snq[$];
	ptp_system_time_unit DUT (
		.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb,
		.prdata, .pready, .pslverr(),
		.rx_frame_valid(rfv), .rx_frame_class(rcl), .rx_msg_field(rmf),
		.rx_snap_valid(rxv), .rx_snap_seconds(rxs), .rx_snap_subseconds(rxu),
		.tx_frame_start(tfs), .tx_snap_valid(txv), .tx_snap_seconds(txs),
		.tx_snap_subseconds(txu), .pps_out(pps), .ts_irq(irq)
	);
	mac_frame_model mac (
		.pclk, .rx_frame_valid(rfv), .rx_frame_class(rcl),
		.rx_msg_field(rmf), .tx_frame_start(tfs)
	);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic test_done;
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic compare(input string n, input logic [31:0] e, g);
		check_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, r1);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m = '1);
		rdq.push_back(e & m);
		rmq.push_back(m);
		apb(1'b0, a, 32'h0, r1);
	endtask
	task automatic frame(input logic tx, input logic [1:0] c,
		input logic [7:0] f, input logic w);
		if (w) begin
			snq.push_back(32'h4);
			snq.push_back(32'hF0);
		end
		mac.send(tx, c, f);
	endtask
	// expected stamping per node, master and event-only
	function automatic logic want(input logic [1:0] n, input logic m, e,
		input logic [3:0] t);
		logic four;
		four = t inside {4'h0, 4'h1, 4'h8, 4'h9};
		case (n)
			2'd2: return e ? (t inside {4'h0, 4'h8}) : four;
			2'd3: return e ? (t inside {4'h0, 4'h2, 4'h3}) : t != 4'hB;
			default: return e ? (t == {3'h0, m}) : four;
		endcase
	endfunction
	// watcher: reads, snapshots, irq and hang limit
	always @(posedge pclk) begin
		cyc++;
		if (cyc > 20000) begin
			n_errors++;
			test_done();
		end
		if (psel && penable && pready === 1'b1 && !pwrite) begin
			compare("read data", rdq.pop_front(), prdata & rmq.pop_front());
		end
		if (rxv === 1'b1 || txv === 1'b1) begin
			if (snq.size() < 2) begin
				compare("unexpected snapshot", 32'h0, 32'h1);
			end else begin
				compare("snap seconds", snq.pop_front(), rxv ? rxs : txs);
				compare("snap subseconds", snq.pop_front(), rxv ? rxu : txu);
			end
		end
		n_irq += (irq === 1'b1);
	end
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hF;
		presetn = 1'b0;
		void'($urandom(32'h95CC3B73));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(ptp_pkg::OFF_TS_CTRL, ptp_pkg::TS_CTRL_RESET);
		rd(ptp_pkg::OFF_SSINC, 32'h0);
		rd(12'h724, 32'h0);
		$display("reset test done");
		// load, then subtract; zero increment keeps time still
		wr(ptp_pkg::OFF_UPD_SEC, 32'h5);
		wr(ptp_pkg::OFF_UPD_SUB, 32'h100);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h2005);
		rd(ptp_pkg::OFF_TS_CTRL, 32'h2001);
		rd(ptp_pkg::OFF_TIME_SEC, 32'h5);
		wr(ptp_pkg::OFF_UPD_SEC, 32'h1);
		wr(ptp_pkg::OFF_UPD_SUB, 32'h8000_0010);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h2009);
		wr(ptp_pkg::OFF_TIME_SEC, 32'hFF);
		rd(ptp_pkg::OFF_TIME_SUB, 32'hF0);
		rd(ptp_pkg::OFF_TIME_SEC, 32'h4);
		rd(ptp_pkg::OFF_TS_CTRL, 32'h2001);
		$display("time load test done");
		// each node, master and event-only setting per kind
		for (int k = 0; k < 16; k++) begin
			ctl = {14'h0, k[3:0], 14'h2401};
			wr(ptp_pkg::OFF_TS_CTRL, ctl);
			foreach (mt[j]) begin
				frame(1'b0, 2'd2, {4'h0, mt[j]}, want(k[3:2], k[1], k[0], mt[j]));
			end
		end
		wr(ptp_pkg::OFF_TS_CTRL, 32'h0801);
		frame(1'b0, 2'd2, 8'h00, 1'b0);
		frame(1'b0, 2'd1, 8'h02, 1'b1);
		frame(1'b0, 2'd1, 8'h04, 1'b0);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h0901);
		frame(1'b0, 2'd0, 8'h0B, 1'b1);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h1401);
		frame(1'b0, 2'd3, 8'h00, 1'b1);
		frame(1'b0, 2'd3, 8'h02, 1'b0);
		frame(1'b1, 2'd0, 8'h00, 1'b1);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h1400);
		frame(1'b0, 2'd3, 8'h00, 1'b0);
		frame(1'b1, 2'd0, 8'h00, 1'b0);
		$display("snapshot test done");
		// coarse step, fine with idle addend, fine with loaded addend
		inc = $urandom_range(255, 1);
		wr(ptp_pkg::OFF_SSINC, inc);
		for (int k = 0; k < 3; k++) begin
			wr(ptp_pkg::OFF_TS_CTRL, k == 0 ? 32'h2001 : 32'h2023);
			if (k == 2) begin
				wr(ptp_pkg::OFF_ADDEND, 32'hFFFF_FFFF);
				wr(ptp_pkg::OFF_TS_CTRL, 32'h2023);
				rd(ptp_pkg::OFF_TS_CTRL, 32'h2003);
			end
			rd(ptp_pkg::OFF_TIME_SUB, 32'h0, 32'h0);
			rd(ptp_pkg::OFF_TIME_SUB, r1 + (k == 1 ? 0 : 3 * inc));
		end
		$display("advance test done");
		// digital wrap carries seconds past the top
		wr(ptp_pkg::OFF_UPD_SEC, 32'hFFFF_FFFF);
		wr(ptp_pkg::OFF_UPD_SUB, 32'h3B9A_C9F0);
		wr(ptp_pkg::OFF_SSINC, 32'h10);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h2205);
		@(posedge pclk);
		rd(ptp_pkg::OFF_TIME_SEC, 32'h0);
		rd(ptp_pkg::OFF_FLAGS, 32'h1, 32'h1);
		compare("pps", 32'h1, {31'h0, pps});
		$display("rollover test done");
		// target far ahead, then an offset jump reaches it
		wr(ptp_pkg::OFF_TGT_SEC, 32'h5);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h2211);
		repeat (20) @(posedge pclk);
		compare("irq count", 32'h0, 32'(n_irq));
		wr(ptp_pkg::OFF_UPD_SEC, 32'h5);
		wr(ptp_pkg::OFF_UPD_SUB, 32'h0);
		wr(ptp_pkg::OFF_TS_CTRL, 32'h2219);
		@(posedge pclk);
		rd(ptp_pkg::OFF_FLAGS, 32'h2, 32'h2);
		rd(ptp_pkg::OFF_FLAGS, 32'h0, 32'h2);
		rd(ptp_pkg::OFF_TS_CTRL, 32'h2201);
		compare("irq count", 32'h1, 32'(n_irq));
		compare("snapshots left", 32'h0, 32'(snq.size()));
		$display("target test done");
		test_done();
	end
endmodule
`default_nettype wire
